// file: logic/fan_status_regs.sv
`timescale 1ns/10ps
// Operation
// - Flags stay set until read after resolution.
// - Still-true conditions set flags next monitor tick, except heat and overspeed flags, which wait to rearm.
// - Local low and high limit flags.
// - Remote low and high limit flags.
// - Sensor fail: sticky, over-temp, minimum reading.
// - Sensor fail alerts when enabled.
// - Remote heat flag, pin low, 5 degC rearm.
// - Local heat flag, pin low, 5 degC rearm.
// - Fan slow flag from count versus limit.
// - No slow check in spin-up; set after.
// - Five slow events assert cooler failure.
// - Fan flags alert when fan irq enabled.
// - Overspeed flag rearms below maximum speed.
// - Heat pin pulled low by others, own drive masked: flag and full speed.
// - Passive cooling flag with optional alert.
// - Critical flags drive over-temp, unmasked alert.
// - Duty is 8-bit code, 0.392 percent steps.
// - Speed mode floors duty at 30 percent unless speed_sense_mode is set.
// - Duty and auto modes cut below 7 percent unless speed_sense_mode is set.
// - Duty writes applied only in software-duty mode.
// - High range frequency table, default code 3.
// - Spin-up at full duty unless disabled.
// - PWM timing derived from 3.2 MHz.
module fan_status_regs
	import fan_status_pkg::*;
#(
	parameter int SPINUP_STEP = SPINUP_STEP_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        soft_reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	output logic             reg_rvalid,
	input  wire temps_s      temps,
	input  wire speed_s      speed,
	input  wire cfg_s        cfg,
	input  wire logic        monitor_tick,
	input  wire logic        sensor_fault,
	input  wire logic [7:0]  calc_duty,
	input  wire logic        spinup_start,
	input  wire logic        range_pin,
	input  wire logic        heat_limit_pin_i,
	output logic             heat_limit_pin_o,
	output logic             heat_limit_pin_oe,
	output logic             smbalert_n,
	output logic             overtemp_output_n,
	output logic             fan_fault_n,
	output logic [7:0]       remote_reading,
	output logic             pwm_out,
	output logic [7:0]       drive_duty
);

	// Power-on and software reset act alike.
	logic rst;
	assign rst = srst | soft_reset;

	// Registers.
	logic [7:0]  st1_q, st1_d;        // First status byte.
	logic [7:0]  st2_q, st2_d;        // Second status byte.
	logic [7:0]  duty_q;              // Written duty code, the shadow.
	logic [7:0]  fs_q;                // Frequency and spin-up settings.
	logic        rem_arm_q;           // Remote heat flag may set.
	logic        loc_arm_q;           // Local heat flag may set.
	logic        ovs_arm_q;           // Overspeed flag may set.
	logic [2:0]  slow_cnt_q;          // Consecutive slow ticks.
	logic        fan_fail_q;          // Fan failure state.
	logic        heat_s1_q, heat_s2_q; // Heat pin synchroniser.
	logic [1:0]  oe_dly_q;            // Own drive, delayed to match the synchroniser.
	logic [6:0]  acc_q;               // Fractional 3.2 MHz accumulator.
	logic [18:0] pwm_cnt_q;           // Position in the PWM period.
	logic        spin_q;              // Spin-up in progress.
	logic [31:0] spin_step_q;         // Cycles within one 200 ms step.
	logic [5:0]  spin_left_q;         // Steps of spin-up still to run.

	// Address decode.
	wire sel_s1   = reg_addr == OFS_STATUS_FIRST;
	wire sel_s2   = reg_addr == OFS_STATUS_SECOND;
	wire sel_fs   = reg_addr == OFS_FREQ_SPINUP;
	wire sel_duty = reg_addr == OFS_DUTY;
	wire rd_s1    = reg_rd & sel_s1;
	wire rd_s2    = reg_rd & sel_s2;

	// Settings fields.
	wire       spinup_disable     = fs_q[FS_DISABLE_BIT];
	wire [2:0] freq_select        = fs_q[FS_FREQ_LSB +: 3];
	wire [2:0] spinup_time_select = fs_q[FS_TIME_LSB +: 3];

	// Temperature comparisons widened to nine bits for the hysteresis.
	wire signed [8:0] loc_t  = 9'(temps.local_temp);
	wire signed [8:0] rem_t  = 9'(temps.remote_temp);
	wire signed [8:0] loc_hl = 9'(temps.local_heat_lim);
	wire signed [8:0] rem_hl = 9'(temps.remote_heat_lim);

	wire c_loc_low  = temps.local_temp <= temps.local_low;
	wire c_loc_high = temps.local_temp >= temps.local_high;
	wire c_rem_low  = temps.remote_temp <= temps.remote_low;
	wire c_rem_high = temps.remote_temp >= temps.remote_high;
	wire c_rem_heat = rem_t > rem_hl;
	wire rem_cool   = rem_t <= rem_hl - HEAT_HYST_DEGC;
	wire c_loc_heat = loc_t > loc_hl;
	wire loc_cool   = loc_t <= loc_hl - HEAT_HYST_DEGC;
	wire c_passive  = temps.control_temp <= temps.passive_temp;
	wire c_loc_crit = temps.local_temp >= temps.local_crit;
	wire c_rem_crit = temps.remote_temp >= temps.remote_crit;
	wire c_slow     = speed.count >= speed.low_limit;
	wire c_fast     = speed.count <= speed.high_limit;
	wire below_max  = speed.count > speed.high_limit;

	// The heat pin reads low only from others; the synchroniser still shows our own
	// drive for two cycles after release, so the delayed enable masks that tail too.
	wire heat_in_low = ~heat_s2_q & ~heat_limit_pin_oe & ~(|oe_dly_q);

	// Spin-up ends when the last step counts out.
	wire spin_done = spin_q && spin_left_q == 6'd1 && spin_step_q == 32'(SPINUP_STEP - 1);

	wire slow_event = monitor_tick & c_slow & ~spin_q;

	// Flag set terms for both status bytes.
	logic [7:0] set1, set2, clr1, clr2;
	always_comb begin
		set1 = 8'h00;
		set2 = 8'h00;
		if (monitor_tick) begin
			set1[S1_LOCAL_LOW]   = c_loc_low;
			set1[S1_LOCAL_HIGH]  = c_loc_high;
			set1[S1_REMOTE_LOW]  = c_rem_low;
			set1[S1_REMOTE_HIGH] = c_rem_high;
			set1[S1_REMOTE_HEAT] = c_rem_heat & rem_arm_q;
			set1[S1_OVERSPEED]   = c_fast & ovs_arm_q;
			set2[S2_LOCAL_HEAT]  = c_loc_heat & loc_arm_q;
			set2[S2_PASSIVE]     = c_passive;
			set2[S2_LOCAL_CRIT]  = c_loc_crit;
			set2[S2_REMOTE_CRIT] = c_rem_crit;
		end
		set1[S1_FAN_SLOW] = slow_event | spin_done;
		set1[S1_SENSOR_FAIL] = sensor_fault;
		set2[S2_HEAT_INPUT] = heat_in_low;
	end

	assign clr1 = rd_s1 ? (st1_q & ~(8'h01 << S1_SENSOR_FAIL)) : 8'h00;
	assign clr2 = rd_s2 ? st2_q : 8'h00;

	assign st1_d = (st1_q & ~clr1) | set1;
	assign st2_d = ((st2_q & ~clr2) | set2) & S2_USED_MASK;

	// Status flags and their re-arm state.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st1_q     <= RST_STATUS;
			st2_q     <= RST_STATUS;
			rem_arm_q <= 1'b1;
			loc_arm_q <= 1'b1;
			ovs_arm_q <= 1'b1;
		end else begin
			st1_q <= st1_d;
			st2_q <= st2_d;
			if (clr1[S1_REMOTE_HEAT] & ~set1[S1_REMOTE_HEAT])
				rem_arm_q <= 1'b0;
			else if (rem_cool)
				rem_arm_q <= 1'b1;
			if (clr2[S2_LOCAL_HEAT] & ~set2[S2_LOCAL_HEAT])
				loc_arm_q <= 1'b0;
			else if (loc_cool)
				loc_arm_q <= 1'b1;
			if (clr1[S1_OVERSPEED] & ~set1[S1_OVERSPEED])
				ovs_arm_q <= 1'b0;
			else if (below_max)
				ovs_arm_q <= 1'b1;
		end
	end

	// Fan failure: a run of slow ticks; any tick outside spin-up that is not slow breaks the run.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			slow_cnt_q <= 3'd0;
			fan_fail_q <= 1'b0;
		end else if (slow_event) begin
			if (slow_cnt_q != FAN_FAIL_COUNT)
				slow_cnt_q <= slow_cnt_q + 3'd1;
			if (slow_cnt_q == FAN_FAIL_COUNT - 3'd1)
				fan_fail_q <= 1'b1;
		end else if (monitor_tick & ~spin_q) begin
			slow_cnt_q <= 3'd0;
		end
	end

	// Heat pin synchroniser; only the second stage is read.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			heat_s1_q <= 1'b1;
			heat_s2_q <= 1'b1;
			oe_dly_q  <= 2'b00;
		end else begin
			heat_s1_q <= heat_limit_pin_i;
			heat_s2_q <= heat_s1_q;
			oe_dly_q  <= {oe_dly_q[0], heat_limit_pin_oe};
		end
	end

	// Alert sources; critical flags bypass every enable.
	wire alert_any =
		(st1_q[S1_SENSOR_FAIL] & cfg.sensor_fail_irq_enable) |
		((st1_q[S1_REMOTE_HEAT] | st2_q[S2_LOCAL_HEAT]) & cfg.heat_limit_irq_enable) |
		((st1_q[S1_FAN_SLOW] | st1_q[S1_OVERSPEED]) & cfg.fan_irq_enable) |
		(st2_q[S2_PASSIVE] & cfg.passive_irq_enable) |
		st2_q[S2_LOCAL_CRIT] | st2_q[S2_REMOTE_CRIT];

	wire overtemp_any = st1_q[S1_SENSOR_FAIL] | st2_q[S2_LOCAL_CRIT] | st2_q[S2_REMOTE_CRIT];

	wire heat_drive = st1_q[S1_REMOTE_HEAT] | st2_q[S2_LOCAL_HEAT];

	// Pin outputs registered, so they trail the flags by one cycle.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			smbalert_n        <= 1'b1;
			overtemp_output_n <= 1'b1;
			heat_limit_pin_oe <= 1'b0;
			fan_fault_n       <= 1'b1;
			remote_reading    <= REMOTE_MIN;
		end else begin
			smbalert_n        <= ~alert_any;
			overtemp_output_n <= ~overtemp_any;
			heat_limit_pin_oe <= heat_drive;
			fan_fault_n       <= ~fan_fail_q;
			remote_reading    <= st1_q[S1_SENSOR_FAIL] ? REMOTE_MIN : temps.remote_temp;
		end
	end

	// The pin is only ever pulled low; releasing it lets the pull-up win.
	assign heat_limit_pin_o = 1'b0;

	wire [7:0] calc = (cfg.mode == MODE_SW_DUTY) ? duty_q : calc_duty;
	wire floor30 = ~cfg.speed_sense_mode & (cfg.mode == MODE_SW_SPEED) & (calc < DUTY_30_PCT);
	wire cut7 = ~cfg.speed_sense_mode & (cfg.mode != MODE_SW_SPEED) & (calc < DUTY_7_PCT);
	wire full = spin_q | heat_in_low;

	wire [7:0] drive_d = full ? DUTY_FULL : floor30 ? DUTY_30_PCT : cut7 ? DUTY_OFF : calc;
	wire [7:0] duty_read = (~full & (floor30 | cut7)) ? calc : drive_d;

	// Register writes and the read port; reads answer one cycle after the strobe.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			duty_q     <= RST_DUTY;
			fs_q       <= RST_FREQ_SPINUP;
			reg_rdata  <= READ_UNMAPPED;
			reg_rvalid <= 1'b0;
		end else begin
			if (reg_wr & sel_duty)
				duty_q <= reg_wdata;
			if (reg_wr & sel_fs)
				fs_q <= reg_wdata & FS_WRITE_MASK;
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				if (sel_s1)
					reg_rdata <= st1_q;
				else if (sel_s2)
					reg_rdata <= st2_q;
				else if (sel_fs)
					reg_rdata <= fs_q;
				else if (sel_duty)
					reg_rdata <= duty_read;
				else
					reg_rdata <= READ_UNMAPPED;
			end
		end
	end

	// Spin-up length in 200 ms steps for each select code.
	logic [5:0] spin_steps;
	always_comb begin
		unique case (spinup_time_select)
			3'd0: spin_steps = 6'd1;
			3'd1: spin_steps = 6'd2;
			3'd2: spin_steps = 6'd3;
			3'd3: spin_steps = 6'd4;
			3'd4: spin_steps = 6'd5;
			3'd5: spin_steps = 6'd10;
			3'd6: spin_steps = 6'd20;
			3'd7: spin_steps = 6'd40;
		endcase
	end

	// Spin-up timer; a fresh start request while running is ignored.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			spin_q      <= 1'b0;
			spin_step_q <= 32'd0;
			spin_left_q <= 6'd0;
		end else if (~spin_q) begin
			if (spinup_start & ~spinup_disable) begin
				spin_q      <= 1'b1;
				spin_step_q <= 32'd0;
				spin_left_q <= spin_steps;
			end
		end else if (spin_step_q == 32'(SPINUP_STEP - 1)) begin
			spin_step_q <= 32'd0;
			spin_left_q <= spin_left_q - 6'd1;
			if (spin_left_q == 6'd1)
				spin_q <= 1'b0;
		end else begin
			spin_step_q <= spin_step_q + 32'd1;
		end
	end

	// fractional 3.2 MHz tick
	// One bit wider than the accumulator so that the sum cannot wrap before the compare.
	wire [7:0] acc_sum = {1'b0, acc_q} + {1'b0, ACC_INC};
	wire       tick32  = acc_sum >= {1'b0, ACC_MOD};
	wire [7:0] acc_rem = acc_sum - {1'b0, ACC_MOD};

	wire [18:0] period = pwm_period(~range_pin, freq_select);

	// The compare scales by 255 so that code 0xff keeps the output on all period long.
	wire [26:0] lhs = 27'(pwm_cnt_q) * 27'd255;
	wire [26:0] rhs = 27'(drive_duty) * 27'(period);

	// PWM counter and output; a frequency change takes effect at once.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			acc_q      <= 7'd0;
			pwm_cnt_q  <= 19'd0;
			pwm_out    <= 1'b0;
			drive_duty <= RST_DUTY;
		end else begin
			acc_q      <= tick32 ? acc_rem[6:0] : acc_sum[6:0];
			drive_duty <= drive_d;
			if (tick32)
				pwm_cnt_q <= (pwm_cnt_q >= period - 19'd1) ? 19'd0 : pwm_cnt_q + 19'd1;
			pwm_out <= lhs < rhs;
		end
	end

endmodule

// file: logic/fan_status_pkg.sv
package fan_status_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFS_STATUS_FIRST  = 8'h02;
	localparam logic [7:0] OFS_STATUS_SECOND = 8'h03;
	localparam logic [7:0] OFS_FREQ_SPINUP   = 8'h20;
	localparam logic [7:0] OFS_DUTY          = 8'h22;

	// Values after reset.
	localparam logic [7:0] RST_STATUS      = 8'h00;
	localparam logic [7:0] RST_DUTY        = 8'h55;
	localparam logic [7:0] RST_FREQ_SPINUP = 8'h1d;
	localparam logic [7:0] READ_UNMAPPED   = 8'h00;

	// Field positions in the frequency and spin-up register.
	localparam int FS_DISABLE_BIT = 7;
	localparam int FS_FREQ_LSB    = 3;
	localparam int FS_TIME_LSB    = 0;
	localparam logic [7:0] FS_WRITE_MASK = 8'hbf;

	// Status bit positions, first register.
	localparam int S1_LOCAL_LOW   = 7;
	localparam int S1_LOCAL_HIGH  = 6;
	localparam int S1_SENSOR_FAIL = 5;
	localparam int S1_REMOTE_HEAT = 4;
	localparam int S1_REMOTE_LOW  = 3;
	localparam int S1_REMOTE_HIGH = 2;
	localparam int S1_FAN_SLOW    = 1;
	localparam int S1_OVERSPEED   = 0;
	// Status bit positions, second register; bits 2..0 read as zero.
	localparam int S2_HEAT_INPUT  = 7;
	localparam int S2_LOCAL_HEAT  = 6;
	localparam int S2_PASSIVE     = 5;
	localparam int S2_LOCAL_CRIT  = 4;
	localparam int S2_REMOTE_CRIT = 3;
	localparam logic [7:0] S2_USED_MASK = 8'hf8;

	// Duty codes: 0x00 is 0 %, 0xff is 100 %, one step is 0.392 %.
	localparam logic [7:0] DUTY_FULL    = 8'hff;
	localparam logic [7:0] DUTY_OFF     = 8'h00;
	localparam logic [7:0] DUTY_30_PCT  = 8'h4d;
	localparam logic [7:0] DUTY_7_PCT   = 8'h12;
	localparam logic [7:0] REMOTE_MIN   = 8'h80;

	// Temperature hysteresis before a heat-limit flag re-arms.
	localparam logic signed [8:0] HEAT_HYST_DEGC = 9'sd5;

	// Consecutive slow events that declare a fan failure.
	localparam logic [2:0] FAN_FAIL_COUNT = 3'd5;

	// Clocks: the PWM time base runs at 3.2 MHz, made from core_clk by a fractional accumulator.
	localparam int CLK_HZ      = 50000000;
	localparam int INT_CLK_HZ  = 3200000;
	localparam int FRAC_GCD    = 400000;
	localparam logic [6:0] ACC_INC = 7'(INT_CLK_HZ / FRAC_GCD);
	localparam logic [6:0] ACC_MOD = 7'(CLK_HZ / FRAC_GCD);

	// Spin-up time unit of 200 ms; the select field picks a multiple of it.
	localparam int SPINUP_STEP_MS     = 200;
	localparam int SPINUP_STEP_CYCLES = SPINUP_STEP_MS * (CLK_HZ / 1000);

	// Fan drive modes.
	typedef enum logic [1:0] {
		MODE_SW_DUTY   = 2'b00,
		MODE_SW_SPEED  = 2'b01,
		MODE_AUTO_REM  = 2'b10,
		MODE_AUTO_MAX  = 2'b11
	} drive_mode_e;

	// Readings and limits from the monitor, signed whole degrees.
	typedef struct packed {
		logic signed [7:0] local_temp;
		logic signed [7:0] remote_temp;
		logic signed [7:0] local_low;
		logic signed [7:0] local_high;
		logic signed [7:0] remote_low;
		logic signed [7:0] remote_high;
		logic signed [7:0] local_heat_lim;
		logic signed [7:0] remote_heat_lim;
		logic signed [7:0] local_crit;
		logic signed [7:0] remote_crit;
		logic signed [7:0] control_temp;
		logic signed [7:0] passive_temp;
	} temps_s;

	// Speed-sense count and its limits; a larger count means a slower fan.
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] low_limit;
		logic [15:0] high_limit;
	} speed_s;

	// Configuration bits held elsewhere in the device.
	typedef struct packed {
		drive_mode_e mode;
		logic        speed_sense_mode;
		logic        heat_limit_irq_enable;
		logic        fan_irq_enable;
		logic        sensor_fail_irq_enable;
		logic        passive_irq_enable;
	} cfg_s;

	// PWM period in 3.2 MHz ticks for each frequency code and range.
	function automatic logic [18:0] pwm_period(input logic high_range, input logic [2:0] code);
		logic [18:0] p;
		p = 19'd0;
		if (high_range) begin
			unique case (code)
				3'd0: p = 19'd3200;
				3'd1: p = 19'd320;
				3'd2: p = 19'd160;
				3'd3: p = 19'd128;
				3'd4: p = 19'd107;
				default: p = 19'd80;
			endcase
		end else begin
			unique case (code)
				3'd0: p = 19'd320000;
				3'd1: p = 19'd213333;
				3'd2: p = 19'd139130;
				3'd3: p = 19'd106667;
				3'd4: p = 19'd84211;
				3'd5: p = 19'd68085;
				3'd6: p = 19'd51613;
				3'd7: p = 19'd34043;
			endcase
		end
		return p;
	endfunction

endpackage

// file: verification/fan_status_regs_sva.sv
`timescale 1ns/10ps
// Port-level checks on the status and duty block.
module fan_status_regs_sva
	import fan_status_pkg::*;
#(
	parameter int SPINUP_STEP = SPINUP_STEP_CYCLES
) (
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       soft_reset,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire temps_s     temps,
	input wire cfg_s       cfg,
	input wire logic       monitor_tick,
	input wire logic       sensor_fault,
	input wire logic       heat_limit_pin_i,
	input wire logic       heat_limit_pin_oe,
	input wire logic       smbalert_n,
	input wire logic       overtemp_output_n,
	input wire logic       fan_fault_n,
	input wire logic [7:0] remote_reading,
	input wire logic [7:0] drive_duty
);
	// Both resets clear everything, so no check spans either.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst || soft_reset);

	AST_RVALID: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	AST_RVALID_ONE: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
	AST_S2_CLEARED: assert property ((reg_rd && reg_addr == OFS_STATUS_SECOND && !monitor_tick)
		##1 (reg_rd && reg_addr == OFS_STATUS_SECOND && !monitor_tick)
		|=> reg_rdata[S2_LOCAL_CRIT] == 1'b0) else $error("critical flag survived read");
	AST_CRIT_PINS: assert property (monitor_tick && temps.local_temp >= temps.local_crit
		|-> ##2 (!overtemp_output_n && !smbalert_n)) else $error("critical pins idle");
	AST_FAIL_OVR: assert property (sensor_fault |-> ##2 !overtemp_output_n) else $error("fail pin idle");
	AST_FAIL_MIN: assert property (sensor_fault |-> ##2 remote_reading == REMOTE_MIN)
		else $error("reading not forced");
	AST_FAIL_ALERT: assert property ((sensor_fault && cfg.sensor_fail_irq_enable)
		##1 cfg.sensor_fail_irq_enable |-> ##1 !smbalert_n) else $error("fail alert idle");
	AST_HEAT_FULL: assert property ((!heat_limit_pin_i && !heat_limit_pin_oe) [*5]
		|-> drive_duty == DUTY_FULL) else $error("heat pin not full");
	AST_FAULT_HOLD: assert property (!fan_fault_n |=> !fan_fault_n) else $error("fan fault dropped");
endmodule

bind fan_status_regs fan_status_regs_sva #(.SPINUP_STEP(SPINUP_STEP)) chk (
	.core_clk(core_clk), .srst(srst), .soft_reset(soft_reset), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temps(temps),
	.cfg(cfg), .monitor_tick(monitor_tick), .sensor_fault(sensor_fault),
	.heat_limit_pin_i(heat_limit_pin_i), .heat_limit_pin_oe(heat_limit_pin_oe),
	.smbalert_n(smbalert_n), .overtemp_output_n(overtemp_output_n),
	.fan_fault_n(fan_fault_n), .remote_reading(remote_reading), .drive_duty(drive_duty));

// file: verification/fan_side_model.sv
`timescale 1ns/10ps
// Monitor tick source and the far end of the heat-limit pin.
module fan_side_model (
	input  wire logic core_clk,
	input  wire logic link_clk,
	input  wire logic tick_req,
	input  wire logic pull_low,
	input  wire logic pin_oe,
	output logic      monitor_tick,
	output logic      heat_pin
);
	logic ext_low_q; // External pull, moved only on link clock edges.

	// One tick pulse per request, in the core domain.
	always_ff @(posedge core_clk) begin
		monitor_tick <= tick_req;
	end

	// The puller lives in its own domain, so its edges are unrelated to core_clk.
	always_ff @(posedge link_clk) begin
		ext_low_q <= pull_low;
	end

	// Open-drain wire with a pull-up: low if either party pulls.
	assign heat_pin = (pin_oe || ext_low_q) ? 1'b0 : 1'b1;
endmodule

// file: verification/test_fan_status_regs.sv
`timescale 1ns/10ps
// Register-level regression of the status and duty block.
module test_fan_status_regs;
	import fan_status_pkg::*;
	logic core_clk = 0, link_clk = 0, srst = 1, soft_reset = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, remote_reading, drive_duty;
	logic reg_wr = 0, reg_rd = 0, reg_rvalid, monitor_tick, sensor_fault = 0;
	logic tick_req = 0, pull_low = 0, spinup_start = 0, heat_pin, pin_oe;
	logic smbalert_n, overtemp_output_n, fan_fault_n, pwm_out;
	logic [7:0] calc_duty = 0;
	temps_s temps;
	speed_s speed;
	cfg_s cfg;
	int error_cnt = 0, n_compared = 0, cycles = 0;

	always #10 core_clk = ~core_clk;
	always #80 link_clk = ~link_clk;

	fan_status_regs #(.SPINUP_STEP(20)) uut (.core_clk(core_clk), .srst(srst),
		.soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temps(temps),
		.speed(speed), .cfg(cfg), .monitor_tick(monitor_tick), .sensor_fault(sensor_fault),
		.calc_duty(calc_duty), .spinup_start(spinup_start), .range_pin(1'b1),
		.heat_limit_pin_i(heat_pin), .heat_limit_pin_o(), .heat_limit_pin_oe(pin_oe),
		.smbalert_n(smbalert_n), .overtemp_output_n(overtemp_output_n), .fan_fault_n(fan_fault_n),
		.remote_reading(remote_reading), .pwm_out(pwm_out), .drive_duty(drive_duty));

	fan_side_model side (.core_clk(core_clk), .link_clk(link_clk), .tick_req(tick_req),
		.pull_low(pull_low), .pin_oe(pin_oe), .monitor_tick(monitor_tick), .heat_pin(heat_pin));

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// The whole run needs a few hundred cycles; a hang stops here.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge core_clk);
		reg_wr = 0;
	endtask

	// The answer stands for the one cycle after the read edge, so it is looked at then.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge core_clk);
		reg_rd = 0;
		chk({7'h0, reg_rvalid}, 8'h01);
		chk(reg_rdata, e);
	endtask

	task automatic tick();
		@(negedge core_clk);
		tick_req = 1;
		@(negedge core_clk);
		tick_req = 0;
		cyc(3);
	endtask

	// Readings that trip no limit at all.
	task automatic benign();
		temps = '{8'sd25, 8'sd25, -8'sd40, 8'sd80, -8'sd40, 8'sd80, 8'sd100, 8'sd100,
			8'sd110, 8'sd110, 8'sd50, 8'sd0};
		speed = '{16'd1000, 16'd2000, 16'd100};
	endtask

	initial begin
		benign();
		cfg = '{MODE_SW_DUTY, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		cyc(10);
		srst = 0;
		// Reset values, read-only status and the unmapped hole.
		wr(OFS_STATUS_FIRST, 8'hff);
		rd(OFS_STATUS_FIRST, 8'h00);
		rd(OFS_STATUS_SECOND, 8'h00);
		rd(OFS_DUTY, 8'h55);
		rd(OFS_FREQ_SPINUP, 8'h1d);
		rd(8'h10, READ_UNMAPPED);
		chk(drive_duty, 8'h55);
		$display("test reset done");
		// Limit flags, clear on read, set again on the next tick.
		temps.local_temp = 8'sd10;
		temps.local_low = 8'sd20;
		temps.remote_temp = 8'sd90;
		tick();
		rd(OFS_STATUS_FIRST, 8'h84);
		rd(OFS_STATUS_FIRST, 8'h00);
		tick();
		rd(OFS_STATUS_FIRST, 8'h84);
		benign();
		tick();
		rd(OFS_STATUS_FIRST, 8'h00);
		$display("test limits done");
		// Local critical and heat limit, with the 5 degree re-arm.
		temps.local_temp = 8'sd120;
		tick();
		chk({7'h0, pin_oe}, 8'h01);
		chk({7'h0, overtemp_output_n}, 8'h00);
		rd(OFS_STATUS_SECOND, 8'h50);
		rd(OFS_STATUS_SECOND, 8'h00);
		tick();
		rd(OFS_STATUS_SECOND, 8'h10);
		temps.local_temp = 8'sd95;
		tick();
		rd(OFS_STATUS_SECOND, 8'h00);
		temps.local_temp = 8'sd120;
		tick();
		rd(OFS_STATUS_SECOND, 8'h50);
		benign();
		tick();
		rd(OFS_STATUS_SECOND, 8'h00);
		rd(OFS_STATUS_FIRST, 8'h40);
		$display("test heat done");
		// Duty floors, shadow register and spin-up.
		wr(OFS_DUTY, 8'h10);
		cyc(3);
		chk(drive_duty, DUTY_OFF);
		rd(OFS_DUTY, 8'h10);
		wr(OFS_DUTY, 8'h80);
		cyc(3);
		chk(drive_duty, 8'h80);
		cfg.mode = MODE_SW_SPEED;
		calc_duty = 8'h20;
		cyc(3);
		chk(drive_duty, DUTY_30_PCT);
		rd(OFS_DUTY, 8'h20);
		wr(OFS_DUTY, 8'h90);
		cyc(3);
		chk(drive_duty, DUTY_30_PCT);
		cfg.mode = MODE_SW_DUTY;
		cyc(3);
		chk(drive_duty, 8'h90);
		wr(OFS_FREQ_SPINUP, 8'h18);
		spinup_start = 1;
		cyc(1);
		spinup_start = 0;
		cyc(3);
		chk(drive_duty, DUTY_FULL);
		cyc(30);
		chk(drive_duty, 8'h90);
		wr(OFS_FREQ_SPINUP, 8'hd8);
		spinup_start = 1;
		cyc(1);
		spinup_start = 0;
		cyc(3);
		chk(drive_duty, 8'h90);
		rd(OFS_FREQ_SPINUP, 8'h98);
		$display("test duty done");
		// Heat pin pulled low from outside.
		pull_low = 1;
		cyc(20);
		chk(drive_duty, DUTY_FULL);
		rd(OFS_STATUS_SECOND, 8'h80);
		pull_low = 0;
		cyc(20);
		rd(OFS_STATUS_SECOND, 8'h80);
		rd(OFS_STATUS_SECOND, 8'h00);
		$display("test heat pin done");
		// Overspeed re-arm, then a slow fan until failure.
		speed.count = 16'd50;
		tick();
		rd(OFS_STATUS_FIRST, 8'h03);
		tick();
		rd(OFS_STATUS_FIRST, 8'h00);
		speed.count = 16'd500;
		tick();
		speed.count = 16'd50;
		tick();
		rd(OFS_STATUS_FIRST, 8'h01);
		speed.count = 16'd3000;
		repeat (5) tick();
		chk({7'h0, fan_fault_n}, 8'h00);
		chk({7'h0, smbalert_n}, 8'h00);
		rd(OFS_STATUS_FIRST, 8'h02);
		$display("test fan done");
		// Sensor failure survives reads and clears on soft reset.
		benign();
		sensor_fault = 1;
		cyc(1);
		sensor_fault = 0;
		cyc(3);
		chk(remote_reading, REMOTE_MIN);
		chk({7'h0, smbalert_n}, 8'h00);
		rd(OFS_STATUS_FIRST, 8'h20);
		rd(OFS_STATUS_FIRST, 8'h20);
		soft_reset = 1;
		cyc(1);
		soft_reset = 0;
		rd(OFS_STATUS_FIRST, 8'h00);
		chk({7'h0, fan_fault_n}, 8'h01);
		$display("test sensor fail done");
		end_of_test();
	end
endmodule
